// ==== hdl/gpfc_pkg.sv ====
// Package for the global pin function configuration bank.
// Assumes an 8-bit index/data configuration port in front of the bank.
package gpfc_pkg;
   localparam logic [7:0] GPFC_OFS_FLASH  = 8'h2A;
   localparam logic [7:0] GPFC_OFS_FIRST  = 8'h2C;
   localparam logic [7:0] GPFC_OFS_SECOND = 8'h2D;
   localparam logic [7:0] GPFC_RST_FLASH  = 8'h00;
   localparam logic [7:0] GPFC_RST_FIRST  = 8'hE2;
   localparam logic [7:0] GPFC_RST_SECOND = 8'h21;
   localparam logic [7:0] GPFC_FIRST_WMASK = 8'hEF;
   localparam int GPFC_FIRST_STRAP_BIT = 4;
   localparam int GPFC_FIRST_VID_BIT   = 3;
   localparam int GPFC_FIRST_GRP_LSB   = 0;
   localparam int GPFC_FIRST_GRP_MSB   = 1;
   localparam int GPFC_FIRST_THERM_BIT = 2;
   localparam int GPFC_FIRST_ROUT_HI_BIT = 7;
   localparam int GPFC_FIRST_ROUT_MSB  = 6;
   localparam int GPFC_FIRST_ROUT_LSB  = 5;
   localparam int GPFC_FLASH_RM_MSB    = 5;
   localparam int GPFC_FLASH_RM_LSB    = 4;
   localparam int GPFC_FLASH_SDA_BIT   = 3;
   localparam int GPFC_FLASH_SCL_BIT   = 2;
   localparam int GPFC_FLASH_TWI_BIT   = 1;
   localparam int GPFC_FLASH_KBMS_BIT  = 0;
   localparam int GPFC_FLASH_CLK_MSB   = 7;
   localparam int GPFC_FLASH_CLK_LSB   = 6;
   localparam logic [7:0] GPFC_RD_NONE = 8'h00;
   localparam int GPFC_RDBYTES_NORMAL  = 1;
   localparam int GPFC_RDBYTES_FAST    = 4;
   localparam int GPFC_MHZ_16 = 16;
   localparam int GPFC_MHZ_22 = 22;
   localparam int GPFC_MHZ_33 = 33;
   localparam logic [1:0] GPFC_CLK_16 = 2'h0;
   localparam logic [1:0] GPFC_CLK_33 = 2'h1;
   localparam logic [1:0] GPFC_CLK_22 = 2'h2;
   localparam logic [1:0] GPFC_RM_NORMAL = 2'h0;
   localparam logic [1:0] GPFC_RM_FAST   = 2'h3;
   localparam logic [1:0] GPFC_GRP_TRI   = 2'h0;
   localparam logic [1:0] GPFC_GRP_IR    = 2'h1;
   localparam logic [1:0] GPFC_GRP_GPIO  = 2'h2;
   localparam logic [1:0] GPFC_GRP_UART  = 2'h3;

   typedef enum logic [1:0] {
      GPFC_GRP_TRISTATE_MODE,
      GPFC_GRP_INFRARED_MODE,
      GPFC_GRP_ALL_GPIO_MODE,
      GPFC_GRP_SECOND_UART_MODE
   } gpfc_group_mode_type;

   typedef struct packed {
      logic [5:0] clock_mhz;
      logic       fast_read;
      logic       dummy_byte;
      logic [2:0] read_bytes;
      logic       active;
   } gpfc_flash_cfg_type;

   typedef struct packed {
      logic                twowire_pins;
      logic                sda_filter_on;
      logic                scl_filter_on;
      logic                kbms_as_gpio;
      logic [2:0]          reset_out_sel;
      logic                power_mgmt_pins;
      logic                vid_threshold_select;
      logic                thermal_shutdown_enable;
      gpfc_group_mode_type group_mode;
      logic [7:0]          second_gpio_sel;
   } gpfc_route_type;
endpackage

// ==== hdl/gpfc_flash_decode.sv ====
// Decodes the serial flash fields into clock rate, read mode and length.
// Assumes the function enable comes from another global register.
`timescale 1ns/100ps
module gpfc_flash_decode (
   input  wire logic                        i_enable,
   input  wire logic [1:0]                  i_clk_sel,
   input  wire logic [1:0]                  i_read_mode,
   output gpfc_pkg::gpfc_flash_cfg_type     o_cfg
);
   import gpfc_pkg::*;

   always_comb begin
      o_cfg            = '0;
      o_cfg.active     = i_enable;
      o_cfg.clock_mhz  = 6'(GPFC_MHZ_16);
      o_cfg.read_bytes = 3'(GPFC_RDBYTES_NORMAL);
      if (i_enable) begin
         if (i_read_mode == GPFC_RM_FAST) begin
            o_cfg.fast_read  = 1'b1;
            o_cfg.dummy_byte = 1'b1;
            o_cfg.clock_mhz  = 6'(GPFC_MHZ_33);
            o_cfg.read_bytes = 3'(GPFC_RDBYTES_FAST);
         end else if (i_read_mode == GPFC_RM_NORMAL) begin
            case (i_clk_sel)
               GPFC_CLK_16: o_cfg.clock_mhz = 6'(GPFC_MHZ_16);
               GPFC_CLK_33: o_cfg.clock_mhz = 6'(GPFC_MHZ_33);
               GPFC_CLK_22: o_cfg.clock_mhz = 6'(GPFC_MHZ_22);
               default:     o_cfg.clock_mhz = 6'(GPFC_MHZ_16);
            endcase
            o_cfg.read_bytes = 3'(GPFC_RDBYTES_NORMAL);
         end
      end
   end
endmodule

// ==== hdl/gpfc_global_config.sv ====
// Global pin function configuration bank: three byte registers at the
// configuration port, decoded into flash settings and pin routing.
// Assumes the index/data port has already been unlocked by software and
// presents one-cycle write and read strobes with an 8-bit index.
//
// Overview of operation
// - Clock select gives 16, 33, 22 MHz in normal read mode 00
// - Flash fields ignored while flash disabled
// - Read mode 00 normal, 11 fast 33MHz
// - Normal read one byte, fast four bytes
// - Bit 3 bypasses data input filter
// - Bit 2 bypasses clock input filter
// - Bit 1 routes shared pins to two-wire bus
// - Bit 0 turns keyboard/mouse pins to GPIO
// - Bits 7..5 choose GPIO or reset output, bits 6..5 only with two-wire bit clear
// - Bit 4 read-only power-management strap
// - Bit 3 strap-loaded VOLTAGE_IDENT_INPUTS threshold select
// - Bit 2 battery-held thermal shutdown enable
// - Bits 1..0 select eight-pin group function
// - Second register bits pick function or GPIO
// - Second register resets to 21h
// - Flash register resets to 00h
// - First register resets to E2h except straps
// - Read mode and thermal enable in battery domain, second register on resume reset, others standby
`timescale 1ns/100ps
module gpfc_global_config (
   input  wire logic                     i_mclk,
   input  wire logic                     i_sys_rst,
   input  wire logic                     i_battery_rst,
   input  wire logic                     i_resume_reset_n,
   input  wire logic                     i_strap_power_mgmt,
   input  wire logic                     i_strap_vid_gtl,
   input  wire logic                     i_flash_enable,
   input  wire logic                     i_wr,
   input  wire logic                     i_rd,
   input  wire logic [7:0]               i_index,
   input  wire logic [7:0]               i_wdata,
   output logic      [7:0]               o_rdata,
   output logic                          o_rvalid,
   output gpfc_pkg::gpfc_flash_cfg_type  o_flash,
   output gpfc_pkg::gpfc_route_type      o_route
);
   import gpfc_pkg::*;

   logic [7:0]         flash_standby;
   logic [1:0]         read_mode;
   logic [7:0]         first_reg;
   logic [7:0]         second_reg;
   logic               strap_power_mgmt;
   logic               strap_taken;
   logic               thermal_bit;
   logic [7:0]         flash_view;
   logic [7:0]         first_view;
   gpfc_flash_cfg_type next_flash;
   gpfc_route_type     next_route;

   // Flash register, standby-domain bits
   always_ff @(posedge i_mclk or posedge i_sys_rst) begin
      if (i_sys_rst) begin
         flash_standby <= GPFC_RST_FLASH;
      end else if (i_wr && i_index == GPFC_OFS_FLASH) begin
         flash_standby <= i_wdata;
      end
   end

   // Read mode field, battery domain
   always_ff @(posedge i_mclk or posedge i_battery_rst) begin
      if (i_battery_rst) begin
         read_mode <= GPFC_RST_FLASH[GPFC_FLASH_RM_MSB:GPFC_FLASH_RM_LSB];
      end else if (i_wr && i_index == GPFC_OFS_FLASH) begin
         read_mode <= i_wdata[GPFC_FLASH_RM_MSB:GPFC_FLASH_RM_LSB];
      end
   end

   // Flash register as software sees it, read mode from battery domain
   always_comb begin
      flash_view = flash_standby;
      flash_view[GPFC_FLASH_RM_MSB:GPFC_FLASH_RM_LSB] = read_mode;
   end

   // First register standby bits; VOLTAGE_IDENT_INPUTS threshold loaded from strap
   always_ff @(posedge i_mclk or posedge i_sys_rst) begin
      if (i_sys_rst) begin
         first_reg   <= GPFC_RST_FIRST;
         strap_taken <= 1'b0;
         strap_power_mgmt <= 1'b0;
      end else begin
         if (!strap_taken) begin
            strap_taken      <= 1'b1;
            strap_power_mgmt <= i_strap_power_mgmt;
            first_reg[GPFC_FIRST_VID_BIT] <= i_strap_vid_gtl;
         end else if (i_wr && i_index == GPFC_OFS_FIRST) begin
            first_reg <= i_wdata & GPFC_FIRST_WMASK;
         end
      end
   end

   // Thermal shutdown enable, battery domain
   always_ff @(posedge i_mclk or posedge i_battery_rst) begin
      if (i_battery_rst) begin
         thermal_bit <= GPFC_RST_FIRST[GPFC_FIRST_THERM_BIT];
      end else if (i_wr && i_index == GPFC_OFS_FIRST) begin
         thermal_bit <= i_wdata[GPFC_FIRST_THERM_BIT];
      end
   end

   always_comb begin
      first_view = first_reg;
      first_view[GPFC_FIRST_STRAP_BIT] = strap_power_mgmt;
      first_view[GPFC_FIRST_THERM_BIT] = thermal_bit;
   end

   // Second register, reset to 21h only by resume reset
   always_ff @(posedge i_mclk or negedge i_resume_reset_n) begin
      if (!i_resume_reset_n) begin
         second_reg <= GPFC_RST_SECOND;
      end else if (i_wr && i_index == GPFC_OFS_SECOND) begin
         second_reg <= i_wdata;
      end
   end

   // Read port
   always_ff @(posedge i_mclk or posedge i_sys_rst) begin
      if (i_sys_rst) begin
         o_rdata  <= GPFC_RD_NONE;
         o_rvalid <= 1'b0;
      end else begin
         o_rvalid <= i_rd;
         if (i_rd) begin
            case (i_index)
               GPFC_OFS_FLASH:  o_rdata <= flash_view;
               GPFC_OFS_FIRST:  o_rdata <= first_view;
               GPFC_OFS_SECOND: o_rdata <= second_reg;
               default:         o_rdata <= GPFC_RD_NONE;
            endcase
         end
      end
   end

   gpfc_flash_decode u_flash_decode (
      .i_enable    (i_flash_enable),
      .i_clk_sel   (flash_view[GPFC_FLASH_CLK_MSB:GPFC_FLASH_CLK_LSB]),
      .i_read_mode (read_mode),
      .o_cfg       (next_flash)
   );

   // Pin routing decode
   always_comb begin
      next_route = '0;
      next_route.twowire_pins  = flash_view[GPFC_FLASH_TWI_BIT];
      next_route.sda_filter_on = ~flash_view[GPFC_FLASH_SDA_BIT];
      next_route.scl_filter_on = ~flash_view[GPFC_FLASH_SCL_BIT];
      next_route.kbms_as_gpio  = flash_view[GPFC_FLASH_KBMS_BIT];
      next_route.reset_out_sel[2] = first_view[GPFC_FIRST_ROUT_HI_BIT];
      if (flash_view[GPFC_FLASH_TWI_BIT]) begin
         next_route.reset_out_sel[1:0] = 2'h0;
      end else begin
         next_route.reset_out_sel[1:0] = first_view[GPFC_FIRST_ROUT_MSB:GPFC_FIRST_ROUT_LSB];
      end
      next_route.power_mgmt_pins         = strap_power_mgmt;
      next_route.vid_threshold_select    = first_view[GPFC_FIRST_VID_BIT];
      next_route.thermal_shutdown_enable = first_view[GPFC_FIRST_THERM_BIT];
      case (first_view[GPFC_FIRST_GRP_MSB:GPFC_FIRST_GRP_LSB])
         GPFC_GRP_TRI:  next_route.group_mode = GPFC_GRP_TRISTATE_MODE;
         GPFC_GRP_IR:   next_route.group_mode = GPFC_GRP_INFRARED_MODE;
         GPFC_GRP_GPIO: next_route.group_mode = GPFC_GRP_ALL_GPIO_MODE;
         GPFC_GRP_UART: next_route.group_mode = GPFC_GRP_SECOND_UART_MODE;
         default:       next_route.group_mode = GPFC_GRP_ALL_GPIO_MODE;
      endcase
      next_route.second_gpio_sel = second_reg;
   end

   always_ff @(posedge i_mclk or posedge i_sys_rst) begin
      if (i_sys_rst) begin
         o_flash <= '0;
         o_route <= '0;
      end else begin
         o_flash <= next_flash;
         o_route <= next_route;
      end
   end
endmodule

// ==== sim/gpfc_checker.sv ====
// Assertions on the ports of the global pin function bank.
// Assumes a bind to gpfc_global_config; binding is at the foot.
`timescale 1ns/100ps
module gpfc_checker
   import gpfc_pkg::*;
(
   input wire logic               i_mclk,
   input wire logic               i_sys_rst,
   input wire logic               i_resume_reset_n,
   input wire logic               i_wr,
   input wire logic               i_rd,
   input wire logic [7:0]         i_index,
   input wire logic [7:0]         i_wdata,
   input wire logic [7:0]         o_rdata,
   input wire logic               o_rvalid,
   input wire gpfc_flash_cfg_type o_flash,
   input wire gpfc_route_type     o_route
);
   default clocking cb @(posedge i_mclk); endclocking
   default disable iff (i_sys_rst);
   sequence s_rd_odd;
      i_rd && !(i_index inside {8'h2A, 8'h2C, 8'h2D});
   endsequence
   sequence s_wr_sec;
      i_wr && i_index == 8'h2D ##1 i_resume_reset_n [*3];
   endsequence
   property p_rvalid;
      i_rd |=> o_rvalid;
   endproperty
   a_rvalid: assert property (p_rvalid) else $error("read without valid");
   property p_unmapped;
      s_rd_odd |=> o_rdata == 8'h00;
   endproperty
   a_unmapped: assert property (p_unmapped) else $error("unmapped read");
   property p_fast;
      o_flash.fast_read |-> o_flash.clock_mhz == 6'h21 && o_flash.read_bytes == 3'h4;
   endproperty
   a_fast: assert property (p_fast) else $error("fast read setup");
   property p_off;
      o_flash.read_bytes != 3'h0 && !o_flash.active |-> !o_flash.fast_read;
   endproperty
   a_off: assert property (p_off) else $error("disabled flash fast");
   property p_clk;
      o_flash.read_bytes != 3'h0 |-> o_flash.clock_mhz inside {6'h10, 6'h16, 6'h21};
   endproperty
   a_clk: assert property (p_clk) else $error("flash clock rate");
   property p_twowire;
      o_route.twowire_pins |-> o_route.reset_out_sel[1:0] == 2'h0;
   endproperty
   a_twowire: assert property (p_twowire) else $error("reset outs on bus");
   property p_second;
      s_wr_sec |-> o_route.second_gpio_sel == $past(i_wdata, 3);
   endproperty
   a_second: assert property (p_second) else $error("second select");
   property p_strap;
      !$past(i_sys_rst, 3) && !$past(i_sys_rst, 2) && !$past(i_sys_rst)
         |-> $stable(o_route.power_mgmt_pins);
   endproperty
   a_strap: assert property (p_strap) else $error("strap bit moved");
endmodule

bind gpfc_global_config gpfc_checker u_checker (
   .i_mclk(i_mclk), .i_sys_rst(i_sys_rst), .i_resume_reset_n(i_resume_reset_n),
   .i_wr(i_wr), .i_rd(i_rd), .i_index(i_index), .i_wdata(i_wdata),
   .o_rdata(o_rdata), .o_rvalid(o_rvalid), .o_flash(o_flash), .o_route(o_route)
);

// ==== sim/gpfc_host_model.sv ====
// Host software model driving the configuration index/data port.
// Assumes the port is already unlocked.
`timescale 1ns/100ps
module gpfc_host_model (
   input  wire logic       i_mclk,
   output logic            o_wr,
   output logic            o_rd,
   output logic [7:0]      o_index,
   output logic [7:0]      o_wdata
);
   initial begin
      o_wr = 1'b0;
      o_rd = 1'b0;
      o_index = 8'h00;
      o_wdata = 8'h00;
   end
   task automatic wr_reg(input logic [7:0] a, input logic [7:0] v);
      @(posedge i_mclk);
      #1;
      o_wr = 1'b1;
      o_index = a;
      o_wdata = v;
      @(posedge i_mclk);
      #1;
      o_wr = 1'b0;
      o_index = ~a;
      o_wdata = ~v;
   endtask
   task automatic rd_reg(input logic [7:0] a);
      @(posedge i_mclk);
      #1;
      o_rd = 1'b1;
      o_index = a;
      @(posedge i_mclk);
      #1;
      o_rd = 1'b0;
      o_index = ~a;
   endtask
endmodule

// ==== sim/global_pin_function_config_tb.sv ====
// Self-checking bench for the global pin function bank.
// Assumes the host model drives the configuration port.
`timescale 1ns/100ps
module global_pin_function_config_tb;
   import gpfc_pkg::*;
   logic               i_mclk = 1'b0;
   logic               i_sys_rst = 1'b1;
   logic               i_battery_rst = 1'b1;
   logic               i_resume_reset_n = 1'b0;
   logic               i_strap_power_mgmt = 1'b1;
   logic               i_strap_vid_gtl = 1'b0;
   logic               i_flash_enable = 1'b0;
   wire logic          i_wr, i_rd;
   wire logic [7:0]    i_index, i_wdata;
   logic [7:0]         o_rdata;
   logic               o_rvalid;
   gpfc_flash_cfg_type o_flash;
   gpfc_route_type     o_route;
   logic [7:0]         r2a = 8'h00, r2c = 8'hF2, r2d = 8'h21, d, idx;
   logic [31:0]        r;
   integer             seed = 17411, n_mismatch = 0, comparisons = 0, k;
   always #5 i_mclk = ~i_mclk;
   gpfc_host_model host (.i_mclk(i_mclk), .o_wr(i_wr), .o_rd(i_rd), .o_index(i_index),
      .o_wdata(i_wdata));
   gpfc_global_config DUT (.i_mclk(i_mclk), .i_sys_rst(i_sys_rst),
      .i_battery_rst(i_battery_rst), .i_resume_reset_n(i_resume_reset_n),
      .i_strap_power_mgmt(i_strap_power_mgmt), .i_strap_vid_gtl(i_strap_vid_gtl),
      .i_flash_enable(i_flash_enable), .i_wr(i_wr), .i_rd(i_rd), .i_index(i_index),
      .i_wdata(i_wdata), .o_rdata(o_rdata), .o_rvalid(o_rvalid), .o_flash(o_flash),
      .o_route(o_route));
   function automatic gpfc_flash_cfg_type exp_flash(input logic en, input logic [7:0] v);
      logic [5:0] mhz;
      mhz = (v[7:6] == 2'h1) ? 6'h21 : (v[7:6] == 2'h2) ? 6'h16 : 6'h10;
      if (!en) return '{6'h10, 1'b0, 1'b0, 3'h1, 1'b0};
      if (v[5:4] == 2'h3) return '{6'h21, 1'b1, 1'b1, 3'h4, 1'b1};
      return '{(v[5:4] == 2'h0) ? mhz : 6'h10, 1'b0, 1'b0, 3'h1, 1'b1};
   endfunction
   function automatic gpfc_route_type exp_route(input logic [7:0] a, c, s);
      return '{a[1], !a[3], !a[2], a[0], {c[7], a[1] ? 2'h0 : c[6:5]}, c[4], c[3], c[2],
         gpfc_group_mode_type'(c[1:0]), s};
   endfunction
   function automatic logic [7:0] exp_rd(input logic [7:0] a);
      return (a == 8'h2A) ? r2a : (a == 8'h2C) ? r2c : (a == 8'h2D) ? r2d : 8'h00;
   endfunction
   task automatic check(input logic [19:0] got, input logic [19:0] exp);
      comparisons++;
      if (got !== exp) begin
         n_mismatch++;
         $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic rdx(input logic [7:0] a);
      host.rd_reg(a);
      check({o_rvalid, o_rdata}, {1'b1, exp_rd(a)});
   endtask
   task automatic wrx(input logic [7:0] a, input logic [7:0] v);
      host.wr_reg(a, v);
      if (a == 8'h2A) r2a = v;
      if (a == 8'h2C) r2c = {v[7:5], r2c[4], v[3:0]};
      if (a == 8'h2D) r2d = v;
      repeat (3) @(posedge i_mclk);
      #1;
      check(o_flash, exp_flash(i_flash_enable, r2a));
      check(o_route, exp_route(r2a, r2c, r2d));
   endtask
   task complete_run;
      $display("Mismatches %0d of %0d comparisons", n_mismatch, comparisons);
      if (n_mismatch == 0 && comparisons > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask
   initial begin
      repeat (6) @(posedge i_mclk);
      #1;
      i_sys_rst = 1'b0;
      i_battery_rst = 1'b0;
      i_resume_reset_n = 1'b1;
      repeat (2) @(posedge i_mclk);
      for (k = 0; k < 4; k++) rdx(8'h2A + k[7:0]);
      for (k = 0; k < 60; k++) begin
         r = $random(seed);
         idx = (k < 16) ? 8'h2A : (k < 20) ? 8'h2C : 8'h2A + {6'h0, r[9:8]};
         d = (k < 16) ? {k[3:0], r[3:0]} : (k < 20) ? {r[7:2], k[1:0]} : r[7:0];
         i_flash_enable = (k < 16) | r[12];
         if (idx == 8'h2A && d[5:4] == 2'h3) d[7:6] = 2'h0;
         wrx(idx, d);
         rdx(idx);
      end
      i_resume_reset_n = 1'b0;
      @(posedge i_mclk);
      #1;
      i_resume_reset_n = 1'b1;
      r2d = 8'h21;
      rdx(8'h2D);
      rdx(8'h2A);
      i_strap_power_mgmt = 1'b0;
      i_strap_vid_gtl = 1'b1;
      i_sys_rst = 1'b1;
      @(posedge i_mclk);
      #1;
      i_sys_rst = 1'b0;
      r2a = {2'h0, r2a[5:4], 4'h0};
      r2c = {3'h7, 1'b0, 1'b1, r2c[2], 2'h2};
      repeat (2) @(posedge i_mclk);
      for (k = 0; k < 4; k++) rdx(8'h2A + k[7:0]);
      check(o_flash, exp_flash(i_flash_enable, r2a));
      check(o_route, exp_route(r2a, r2c, r2d));
      i_battery_rst = 1'b1;
      @(posedge i_mclk);
      #1;
      i_battery_rst = 1'b0;
      r2a[5:4] = 2'h0;
      r2c[2] = 1'b0;
      rdx(8'h2A);
      rdx(8'h2C);
      check(o_flash, exp_flash(i_flash_enable, r2a));
      check(o_route, exp_route(r2a, r2c, r2d));
      complete_run;
   end
   initial begin
      #100000;
      n_mismatch++;
      complete_run;
   end
endmodule
